//--- core/pdc_channel.sv
// peripheral dma channel: descriptors, arbitration against interrupts,
// transfer sequencing, end-of-block request and two-table swap.
// assumes bus read data arrive the cycle after a request is presented,
// and that a memory access is stretched while bus_wait_i is high.
`timescale 1ns/1ps
`default_nettype none

module pdc_channel #(
	parameter int unsigned SAMPLE_CYC = pdc_pkg::SAMPLE_PERIOD,
	parameter int unsigned RF_CYC     = pdc_pkg::RF_XFER_CYC,
	parameter int unsigned MEM_CYC    = pdc_pkg::MEM_XFER_CYC
) (
	input  wire logic              core_clk_i,
	input  wire logic              resetn_i,
	input  wire logic [2:0]        reg_addr_i,
	input  wire logic [7:0]        reg_wdata_i,
	input  wire logic              reg_we_i,
	input  wire logic              reg_re_i,
	output logic      [7:0]        reg_rdata_o,
	input  wire logic              periph_event_i,
	input  wire logic              periph_to_mem_i,
	input  wire logic [7:0]        periph_rdata_i,
	output logic      [7:0]        periph_wdata_o,
	output logic                   periph_we_o,
	input  wire logic [2:0]        current_priority_i,
	input  wire logic              int_req_i,
	input  wire logic [2:0]        int_level_i,
	input  wire logic              top_priority_interrupt_i,
	input  wire logic              instr_end_i,
	output var pdc_pkg::pdc_bus_t  bus_o,
	input  wire logic [7:0]        bus_rdata_i,
	input  wire logic              bus_wait_i,
	output logic                   dma_grant_o,
	output logic                   dma_busy_o,
	output logic                   eob_irq_o,
	output logic      [2:0]        eob_level_o,
	input  wire logic              eob_ack_i
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	pdc_pkg::pdc_state_t state_r;
	pdc_pkg::pdc_bus_t   bus_r;
	logic [7:0]  counter_pointer_reg_r;
	logic [7:0]  address_pointer_reg_r;
	logic        pending_flag_r;
	logic        transfer_request_mask_r;
	logic        block_end_irq_mask_r;
	logic [2:0]  source_priority_r;
	logic        swap_en_r;
	logic        table_r;
	logic        eob_r;
	logic        eob_req_r;
	logic [2:0]  eob_level_r;
	logic        grant_r;
	logic [3:0]  samp_cnt_r;
	logic [3:0]  cyc_r;
	logic        rf_mode_r;
	logic        to_mem_r;
	logic        seg_r;
	logic [15:0] cnt_r;
	logic [15:0] addr_r;
	logic [7:0]  rdata_r;
	logic [7:0]  pwdata_r;
	logic        pwe_r;

	// ----------------------------------------------------------------
	// arbitration terms
	// ----------------------------------------------------------------
	logic        tick;
	logic        dma_req;
	logic        dma_ok;
	logic        int_beats;
	logic        dma_win;
	logic        ack;
	logic        xfer_end;
	logic        blk_end;
	logic [3:0]  last_cyc;
	logic [7:0]  cnt_base;
	logic [7:0]  adr_base;
	logic [7:0]  tbl_off;

	assign tick    = (samp_cnt_r == 4'(SAMPLE_CYC - 1));
	assign dma_req = pending_flag_r & transfer_request_mask_r;
	// lower code is higher priority, so "equal or higher" is <=
	assign dma_ok  = dma_req & ~top_priority_interrupt_i
		& (source_priority_r <= current_priority_i);
	// an interrupt only beats us from a strictly higher level
	assign int_beats = int_req_i & (int_level_i < source_priority_r)
		& (int_level_i < current_priority_i);
	assign dma_win  = tick & dma_ok & ~int_beats;
	assign ack      = (state_r == pdc_pkg::PDC_IDLE) & dma_win;
	assign last_cyc = rf_mode_r ? 4'(RF_CYC - 1) : 4'(MEM_CYC - 1);
	assign xfer_end = (state_r == pdc_pkg::PDC_XFER) & (cyc_r == last_cyc);
	assign blk_end  = xfer_end & (cnt_r == 16'h0000);

	// second table sits one descriptor step above the first
	assign tbl_off  = table_r ? pdc_pkg::TBL_STEP : 8'h00;
	assign cnt_base = {counter_pointer_reg_r[7:1], 1'b0} + tbl_off;
	assign adr_base = {address_pointer_reg_r[7:1], 1'b0} + tbl_off;

	// ----------------------------------------------------------------
	// request sampler
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			samp_cnt_r <= 4'h0;
		end else if (tick) begin
			samp_cnt_r <= 4'h0;
		end else begin
			samp_cnt_r <= samp_cnt_r + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			counter_pointer_reg_r <= pdc_pkg::RST_PTR;
			address_pointer_reg_r <= pdc_pkg::RST_PTR;
			block_end_irq_mask_r  <= 1'b0;
			source_priority_r     <= pdc_pkg::RST_PRI;
			swap_en_r             <= 1'b0;
		end else if (reg_we_i) begin
			unique case (reg_addr_i)
				pdc_pkg::OFF_CPTR: counter_pointer_reg_r <= reg_wdata_i;
				pdc_pkg::OFF_APTR: address_pointer_reg_r <= reg_wdata_i;
				pdc_pkg::OFF_CTRL: begin
					block_end_irq_mask_r <= reg_wdata_i[pdc_pkg::CTRL_IMSK];
					source_priority_r    <= reg_wdata_i[pdc_pkg::CTRL_PRI_LSB +: 3];
				end
				pdc_pkg::OFF_SWAP: swap_en_r <= reg_wdata_i[pdc_pkg::SWAP_EN];
				default: ;
			endcase
		end
	end

	// pending flag: hardware event beats both acknowledge and software
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pending_flag_r <= 1'b0;
		end else if (periph_event_i) begin
			pending_flag_r <= 1'b1;
		end else if (reg_we_i && reg_addr_i == pdc_pkg::OFF_CTRL) begin
			pending_flag_r <= reg_wdata_i[pdc_pkg::CTRL_PEND];
		end else if (ack) begin
			pending_flag_r <= 1'b0;
		end
	end

	// request mask: a software write in the same cycle overrides the clear
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			transfer_request_mask_r <= 1'b0;
		end else if (reg_we_i && reg_addr_i == pdc_pkg::OFF_CTRL) begin
			transfer_request_mask_r <= reg_wdata_i[pdc_pkg::CTRL_MASK];
		end else if (blk_end && !swap_en_r) begin
			transfer_request_mask_r <= 1'b0;
		end
	end

	// table select toggles at each block end while swapping
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			table_r <= 1'b0;
		end else if (!swap_en_r) begin
			table_r <= 1'b0;
		end else if (blk_end) begin
			table_r <= ~table_r;
		end
	end

	// ----------------------------------------------------------------
	// end-of-block request
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			eob_r <= 1'b0;
		end else if (blk_end && block_end_irq_mask_r) begin
			eob_r <= 1'b1;
		end else if (eob_ack_i) begin
			eob_r <= 1'b0;
		end
	end

	// presented at sample ticks; held back while our own dma request is allowed (dma_ok), even if an interrupt beats it
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			eob_req_r   <= 1'b0;
			eob_level_r <= pdc_pkg::RST_PRI;
		end else if (eob_ack_i) begin
			eob_req_r <= 1'b0;
		end else if (tick) begin
			eob_level_r <= source_priority_r;
			eob_req_r   <= eob_r & ~dma_ok
				& (source_priority_r < current_priority_i);
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r   <= pdc_pkg::PDC_IDLE;
			grant_r   <= 1'b0;
			rf_mode_r <= 1'b0;
			to_mem_r  <= 1'b0;
			seg_r     <= 1'b0;
		end else begin
			unique case (state_r)
				pdc_pkg::PDC_IDLE: begin
					if (ack) begin
						state_r   <= pdc_pkg::PDC_WAIT;
						grant_r   <= 1'b1;
						// freeze mode bits so a rewrite cannot tear a transfer
						rf_mode_r <= counter_pointer_reg_r[pdc_pkg::SEL_BIT];
						seg_r     <= address_pointer_reg_r[pdc_pkg::SEL_BIT];
						to_mem_r  <= periph_to_mem_i;
					end
				end
				pdc_pkg::PDC_WAIT: begin
					if (instr_end_i) begin
						state_r <= pdc_pkg::PDC_XFER;
					end
				end
				pdc_pkg::PDC_XFER: begin
					// no exit but the last cycle: nothing can cut it short
					if (xfer_end) begin
						state_r <= pdc_pkg::PDC_IDLE;
						grant_r <= 1'b0;
					end
				end
			endcase
		end
	end

	// cycle counter; memory data access holds while stretched
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cyc_r <= 4'h0;
		end else if (state_r != pdc_pkg::PDC_XFER || xfer_end) begin
			cyc_r <= 4'h0;
		end else if (!(!rf_mode_r && cyc_r == 4'h7 && bus_wait_i)) begin
			cyc_r <= cyc_r + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// descriptor and data schedule
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bus_r    <= '0;
			cnt_r    <= 16'h0000;
			addr_r   <= 16'h0000;
			pwdata_r <= 8'h00;
			pwe_r    <= 1'b0;
		end else begin
			bus_r <= '0;
			pwe_r <= 1'b0;
			if (state_r == pdc_pkg::PDC_XFER && rf_mode_r) begin
				// 8-bit descriptors: address even, counter odd
				unique case (cyc_r)
					4'h0: bus_r <= '{1'b1, 1'b0, 1'b1, 1'b0, {8'h00, cnt_base}, 8'h00};
					4'h1: bus_r <= '{1'b1, 1'b0, 1'b1, 1'b0,
						{8'h00, cnt_base + 8'h01}, 8'h00};
					4'h2: addr_r <= {8'h00, bus_rdata_i};
					4'h3: begin
						cnt_r <= {8'h00, bus_rdata_i};
						bus_r <= '{1'b1, to_mem_r, 1'b1, 1'b0, addr_r,
							periph_rdata_i};
					end
					4'h4: begin
						addr_r <= {8'h00, addr_r[7:0] + 8'h01};
						cnt_r  <= cnt_r - 16'h0001;
					end
					4'h5: begin
						if (!to_mem_r) begin
							pwdata_r <= bus_rdata_i;
							pwe_r    <= 1'b1;
						end
						bus_r <= '{1'b1, 1'b1, 1'b1, 1'b0, {8'h00, cnt_base},
							addr_r[7:0]};
					end
					4'h6: bus_r <= '{1'b1, 1'b1, 1'b1, 1'b0,
						{8'h00, cnt_base + 8'h01}, cnt_r[7:0]};
					default: ;
				endcase
			end else if (state_r == pdc_pkg::PDC_XFER) begin
				// 16-bit pairs, counter via one pointer, address via other
				unique case (cyc_r)
					4'h0: bus_r <= '{1'b1, 1'b0, 1'b1, 1'b0, {8'h00, cnt_base}, 8'h00};
					4'h1: bus_r <= '{1'b1, 1'b0, 1'b1, 1'b0,
						{8'h00, cnt_base + 8'h01}, 8'h00};
					4'h2: begin
						cnt_r[15:8] <= bus_rdata_i;
						bus_r <= '{1'b1, 1'b0, 1'b1, 1'b0, {8'h00, adr_base}, 8'h00};
					end
					4'h3: begin
						cnt_r[7:0] <= bus_rdata_i;
						bus_r <= '{1'b1, 1'b0, 1'b1, 1'b0,
							{8'h00, adr_base + 8'h01}, 8'h00};
					end
					4'h4: addr_r[15:8] <= bus_rdata_i;
					4'h5: addr_r[7:0] <= bus_rdata_i;
					4'h6: bus_r <= '{1'b1, to_mem_r, 1'b0, seg_r, addr_r,
						periph_rdata_i};
					4'h7: begin
						if (bus_wait_i) begin
							bus_r <= bus_r;
						end
					end
					4'h8: begin
						if (!to_mem_r) begin
							pwdata_r <= bus_rdata_i;
							pwe_r    <= 1'b1;
						end
						addr_r <= addr_r + 16'h0001;
						cnt_r  <= cnt_r - 16'h0001;
					end
					4'h9: bus_r <= '{1'b1, 1'b1, 1'b1, 1'b0, {8'h00, adr_base},
						addr_r[15:8]};
					4'ha: bus_r <= '{1'b1, 1'b1, 1'b1, 1'b0,
						{8'h00, adr_base + 8'h01}, addr_r[7:0]};
					4'hb: bus_r <= '{1'b1, 1'b1, 1'b1, 1'b0, {8'h00, cnt_base},
						cnt_r[15:8]};
					4'hc: bus_r <= '{1'b1, 1'b1, 1'b1, 1'b0,
						{8'h00, cnt_base + 8'h01}, cnt_r[7:0]};
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// register read port, data valid one cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_r <= 8'h00;
		end else if (reg_re_i) begin
			unique case (reg_addr_i)
				pdc_pkg::OFF_CPTR: rdata_r <= counter_pointer_reg_r;
				pdc_pkg::OFF_APTR: rdata_r <= address_pointer_reg_r;
				pdc_pkg::OFF_CTRL: rdata_r <= {2'b00, pending_flag_r,
					transfer_request_mask_r, block_end_irq_mask_r, source_priority_r};
				pdc_pkg::OFF_SWAP: rdata_r <= {7'h00, swap_en_r};
				pdc_pkg::OFF_STAT: rdata_r <= {5'h00, eob_r, table_r,
					state_r != pdc_pkg::PDC_IDLE};
				default: rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata_o    = rdata_r;
	assign periph_wdata_o = pwdata_r;
	assign periph_we_o    = pwe_r;
	assign bus_o          = bus_r;
	assign dma_grant_o    = grant_r;
	assign dma_busy_o     = grant_r;
	assign eob_irq_o      = eob_req_r;
	assign eob_level_o    = eob_level_r;

endmodule

`default_nettype wire

//--- core/pdc_pkg.sv
// constants and carrier types for the peripheral dma channel.
// assumes one core clock domain and a byte-wide register port.
package pdc_pkg;

	// ----------------------------------------------------------------
	// register offsets on the local register port
	// ----------------------------------------------------------------
	localparam int unsigned REG_AW   = 3;
	localparam logic [2:0]  OFF_CPTR = 3'h0;
	localparam logic [2:0]  OFF_APTR = 3'h1;
	localparam logic [2:0]  OFF_CTRL = 3'h2;
	localparam logic [2:0]  OFF_SWAP = 3'h3;
	localparam logic [2:0]  OFF_STAT = 3'h4;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned SEL_BIT      = 0;
	localparam int unsigned CTRL_PEND    = 5;
	localparam int unsigned CTRL_MASK    = 4;
	localparam int unsigned CTRL_IMSK    = 3;
	localparam int unsigned CTRL_PRI_LSB = 0;
	localparam int unsigned SWAP_EN      = 0;
	localparam int unsigned STAT_BUSY    = 0;
	localparam int unsigned STAT_TABLE   = 1;
	localparam int unsigned STAT_EOB     = 2;

	// ----------------------------------------------------------------
	// reset values and table step
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_PTR  = 8'h00;
	localparam logic [2:0] RST_PRI  = 3'h7;
	localparam logic [7:0] TBL_STEP = 8'h02;

	// ----------------------------------------------------------------
	// timing counts in core clock cycles
	// ----------------------------------------------------------------
	localparam int unsigned SAMPLE_PERIOD = 5;
	localparam int unsigned RF_XFER_CYC   = 8;
	localparam int unsigned MEM_XFER_CYC  = 16;

	typedef enum logic [2:0] {
		PDC_IDLE = 3'b001,
		PDC_WAIT = 3'b010,
		PDC_XFER = 3'b100
	} pdc_state_t;

	// one access toward register file or memory
	typedef struct packed {
		logic        req;
		logic        we;
		logic        space_rf;
		logic        seg_sel;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} pdc_bus_t;

endpackage

//--- verif/pdc_chk.sv
// port checker for the peripheral dma channel.
// assumes a bind onto pdc_channel, one clock and an async low reset.
`timescale 1ns/1ps
`default_nettype none
module pdc_chk #(
	parameter int unsigned SAMPLE_CYC = 5,
	parameter int unsigned RF_CYC     = 8,
	parameter int unsigned MEM_CYC    = 16
) (
	input wire logic              core_clk_i,
	input wire logic              resetn_i,
	input wire logic              instr_end_i,
	input wire logic              top_priority_interrupt_i,
	input var  pdc_pkg::pdc_bus_t bus_o,
	input wire logic              dma_grant_o,
	input wire logic              dma_busy_o,
	input wire logic              periph_we_o
);
	// ----------------------------------------------------------------
	// helper state
	// ----------------------------------------------------------------
	logic       ended_r;
	logic       gq_r;
	logic       ref_ok_r;
	logic [7:0] cnt_r;
	logic [2:0] ph_r;
	logic [2:0] ref_r;
	// cycles of grant after the instruction end was seen
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ended_r <= 1'b0;
			cnt_r   <= 8'h00;
		end else begin
			ended_r <= dma_grant_o && (ended_r || instr_end_i);
			cnt_r   <= (dma_grant_o && ended_r) ? cnt_r + 8'h01 : 8'h00;
		end
	end
	// phase is unknown to us, so the first grant fixes it for the rest
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ph_r     <= 3'h0;
			gq_r     <= 1'b0;
			ref_ok_r <= 1'b0;
			ref_r    <= 3'h0;
		end else begin
			ph_r <= (ph_r == 3'(SAMPLE_CYC - 1)) ? 3'h0 : ph_r + 3'h1;
			gq_r <= dma_grant_o;
			if (dma_grant_o && !gq_r && !ref_ok_r) begin
				ref_ok_r <= 1'b1;
				ref_r    <= ph_r;
			end
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_end_seen;
		dma_grant_o && instr_end_i && !ended_r;
	endsequence
	a_min_len: assert property (s_end_seen |=> dma_grant_o [*8])
		else $error("transfer shorter than a register file transfer");
	a_xfer_len: assert property (!dma_grant_o && gq_r && ended_r
		|-> cnt_r == RF_CYC || cnt_r >= MEM_CYC)
		else $error("transfer length off");
	a_after_instr: assert property (bus_o.req |-> ended_r)
		else $error("bus access before instruction end");
	a_req_in_grant: assert property (bus_o.req |-> dma_grant_o && dma_busy_o)
		else $error("bus access outside grant");
	a_top_blocks: assert property (top_priority_interrupt_i && !dma_grant_o |=> !dma_grant_o)
		else $error("grant during top priority service");
	a_tick_phase: assert property (dma_grant_o && !gq_r && ref_ok_r |-> ph_r == ref_r)
		else $error("grant off the sampling tick");
	a_one_byte: assert property (periph_we_o |-> dma_grant_o ##1 !periph_we_o)
		else $error("peripheral write not a single pulse");
	a_rf_page: assert property (bus_o.req && bus_o.space_rf |-> bus_o.addr[15:8] == 8'h00)
		else $error("register file address beyond one byte");
endmodule
`default_nettype wire

//--- verif/pdc_mem_model.sv
// register file and memory standing behind the channel bus.
// assumes one access per request; memory data accesses may be stretched.
`timescale 1ns/1ps
`default_nettype none
module pdc_mem_model (
	input  wire logic              core_clk_i,
	input  wire logic              resetn_i,
	input  var  pdc_pkg::pdc_bus_t bus_i,
	input  wire logic [3:0]        wait_len_i,
	output logic                   wait_o,
	output logic      [7:0]        rdata_o
);
	// ----------------------------------------------------------------
	// storage and wait states
	// ----------------------------------------------------------------
	logic [7:0] rf [256];
	logic [7:0] mem [256];
	logic [3:0] wcnt_r;
	logic       go;
	assign wait_o = bus_i.req && !bus_i.space_rf && (wcnt_r < wait_len_i);
	assign go     = bus_i.req && !wait_o;
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wcnt_r <= 4'h0;
		end else begin
			wcnt_r <= wait_o ? wcnt_r + 4'h1 : 4'h0;
		end
	end
	// read data only in the answer cycle; otherwise the lines keep toggling
	always @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= 8'h00;
		end else if (go && !bus_i.we) begin
			rdata_o <= bus_i.space_rf ? rf[bus_i.addr[7:0]] : mem[bus_i.addr[7:0]];
		end else begin
			rdata_o <= ~rdata_o;
			if (go && bus_i.space_rf) rf[bus_i.addr[7:0]] <= bus_i.wdata;
			if (go && !bus_i.space_rf) mem[bus_i.addr[7:0]] <= bus_i.wdata;
		end
	end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the peripheral dma channel.
// assumes the checker and the bus partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic              core_clk_i, resetn_i, reg_we, reg_re, periph_event, periph_to_mem;
	logic              periph_we, int_req, top_int, instr_end, bus_wait, grant, busy;
	logic              eob_irq, eob_ack, seg_seen;
	logic [2:0]        reg_addr, current_priority, int_level, eob_level;
	logic [3:0]        wait_len;
	logic [7:0]        reg_wdata, reg_rdata, periph_rdata, periph_wdata, bus_rdata, last_pw;
	pdc_pkg::pdc_bus_t bus;
	int                bad_count, total_checks;

	pdc_channel u_pdc_channel (
		.core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re), .reg_rdata_o(reg_rdata),
		.periph_event_i(periph_event), .periph_to_mem_i(periph_to_mem),
		.periph_rdata_i(periph_rdata), .periph_wdata_o(periph_wdata), .periph_we_o(periph_we),
		.current_priority_i(current_priority), .int_req_i(int_req), .int_level_i(int_level),
		.top_priority_interrupt_i(top_int), .instr_end_i(instr_end), .bus_o(bus),
		.bus_rdata_i(bus_rdata), .bus_wait_i(bus_wait), .dma_grant_o(grant),
		.dma_busy_o(busy), .eob_irq_o(eob_irq), .eob_level_o(eob_level), .eob_ack_i(eob_ack));
	pdc_mem_model u_pdc_mem_model (
		.core_clk_i(core_clk_i), .resetn_i(resetn_i), .bus_i(bus), .wait_len_i(wait_len),
		.wait_o(bus_wait), .rdata_o(bus_rdata));

	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		if (periph_we) last_pw <= periph_wdata;
		if (bus.req && !bus.space_rf) seg_seen <= bus.seg_sel;
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge core_clk_i);
		reg_we <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic rchk(input logic [2:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge core_clk_i);
		reg_re <= 1'b0;
		@(negedge core_clk_i);
		chk(reg_rdata, e);
		@(posedge core_clk_i);
	endtask
	task automatic no_grant;
		repeat (12) @(negedge core_clk_i);
		chk(grant, 1'b0);
		@(posedge core_clk_i);
	endtask
	// grant, then end the instruction and count the cycles the grant stands
	task automatic run_xfer(input logic [15:0] len);
		int n;
		n = 0;
		while (grant !== 1'b1) begin
			@(negedge core_clk_i);
			n++;
			if (n > 20) begin
				chk(grant, 1'b1);
				end_sim;
			end
		end
		chk(busy, 1'b1);
		@(posedge core_clk_i);
		instr_end <= 1'b1;
		@(posedge core_clk_i);
		instr_end <= 1'b0;
		n = 0;
		while (n < 40) begin
			@(negedge core_clk_i);
			if (grant !== 1'b1) break;
			n++;
		end
		chk(16'(n), len);
		@(posedge core_clk_i);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rchk(pdc_pkg::OFF_CTRL, 8'h07);
		rchk(pdc_pkg::OFF_CPTR, 8'h00);
		chk(eob_level, 3'h7);
		$display("test reset finished");
	endtask
	task automatic t_rf;
		u_pdc_mem_model.rf[8'h20] = 8'h40; // address even, counter odd
		u_pdc_mem_model.rf[8'h21] = 8'h02;
		periph_to_mem <= 1'b1;
		periph_rdata <= 8'h5a;
		int_req <= 1'b1;
		int_level <= 3'h3;
		wr(pdc_pkg::OFF_CPTR, 8'h21);
		wr(pdc_pkg::OFF_CTRL, 8'h3b);
		run_xfer(16'h0008); // interrupt at the same level waits
		chk(u_pdc_mem_model.rf[8'h40], 8'h5a);
		chk(u_pdc_mem_model.rf[8'h20], 8'h41);
		chk(u_pdc_mem_model.rf[8'h21], 8'h01);
		rchk(pdc_pkg::OFF_CTRL, 8'h1b);
		periph_event <= 1'b1;
		@(posedge core_clk_i);
		periph_event <= 1'b0;
		run_xfer(16'h0008);
		chk(u_pdc_mem_model.rf[8'h41], 8'h5a);
		rchk(pdc_pkg::OFF_CTRL, 8'h0b);
		repeat (12) begin
			@(negedge core_clk_i);
			if (eob_irq === 1'b1) break;
		end
		chk(eob_irq, 1'b1);
		chk(eob_level, 3'h3);
		@(posedge core_clk_i);
		eob_ack <= 1'b1;
		@(posedge core_clk_i);
		eob_ack <= 1'b0;
		repeat (2) @(negedge core_clk_i);
		chk(eob_irq, 1'b0);
		$display("test register file finished");
	endtask
	task automatic t_prio;
		u_pdc_mem_model.rf[8'h30] = 8'h50;
		u_pdc_mem_model.rf[8'h31] = 8'h02;
		int_req <= 1'b0;
		current_priority <= 3'h4;
		wr(pdc_pkg::OFF_CPTR, 8'h31);
		wr(pdc_pkg::OFF_CTRL, 8'h35);
		no_grant;
		current_priority <= 3'h6;
		int_req <= 1'b1;
		int_level <= 3'h4;
		no_grant;
		int_req <= 1'b0;
		current_priority <= 3'h5;
		top_int <= 1'b1;
		no_grant;
		top_int <= 1'b0;
		run_xfer(16'h0008);
		current_priority <= 3'h0;
		wr(pdc_pkg::OFF_CTRL, 8'h30);
		run_xfer(16'h0008);
		$display("test priority finished");
	endtask
	task automatic t_mem;
		u_pdc_mem_model.rf[8'h10] = 8'h00; // counter pair, high byte first
		u_pdc_mem_model.rf[8'h11] = 8'h01;
		u_pdc_mem_model.rf[8'h14] = 8'h00;
		u_pdc_mem_model.rf[8'h15] = 8'h80;
		u_pdc_mem_model.mem[8'h80] = 8'hc3;
		periph_to_mem <= 1'b0;
		current_priority <= 3'h7;
		wait_len <= 4'h2;
		wr(pdc_pkg::OFF_CPTR, 8'h10);
		wr(pdc_pkg::OFF_APTR, 8'h15);
		wr(pdc_pkg::OFF_CTRL, 8'h37);
		run_xfer(16'h0012);
		chk(last_pw, 8'hc3);
		chk(seg_seen, 1'b1);
		chk(u_pdc_mem_model.rf[8'h15], 8'h81);
		chk(u_pdc_mem_model.rf[8'h11], 8'h00);
		$display("test memory finished");
	endtask
	// two tables in the register file; each block ends after one byte
	task automatic t_swap;
		u_pdc_mem_model.rf[8'h60] = 8'h70; // table 0 address and counter
		u_pdc_mem_model.rf[8'h61] = 8'h01;
		u_pdc_mem_model.rf[8'h62] = 8'h78; // table 1 sits two registers up
		u_pdc_mem_model.rf[8'h63] = 8'h01;
		periph_to_mem <= 1'b1;
		periph_rdata <= 8'ha5;
		wr(pdc_pkg::OFF_SWAP, 8'h01);
		wr(pdc_pkg::OFF_CPTR, 8'h61);
		wr(pdc_pkg::OFF_CTRL, 8'h3e);
		run_xfer(16'h0008);
		chk(u_pdc_mem_model.rf[8'h70], 8'ha5);
		rchk(pdc_pkg::OFF_CTRL, 8'h1e); // mask kept
		rchk(pdc_pkg::OFF_STAT, 8'h06); // end-of-block and table 1
		periph_rdata <= 8'h3c;
		periph_event <= 1'b1;
		@(posedge core_clk_i);
		periph_event <= 1'b0;
		run_xfer(16'h0008);
		chk(u_pdc_mem_model.rf[8'h78], 8'h3c);
		chk(u_pdc_mem_model.rf[8'h62], 8'h79);
		rchk(pdc_pkg::OFF_STAT, 8'h04); // back on table 0
		$display("test swap finished");
	endtask

	initial begin
		{resetn_i, reg_we, reg_re, periph_event, periph_to_mem, int_req} = 6'h00;
		{top_int, instr_end, eob_ack, seg_seen} = 4'h0;
		{reg_addr, int_level, wait_len} = 10'h000;
		{reg_wdata, periph_rdata, last_pw} = 24'h000000;
		current_priority = 3'h7;
		bad_count = 0;
		total_checks = 0;
		repeat (16) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		@(posedge core_clk_i);
		t_reset;
		t_rf;
		t_prio;
		t_mem;
		t_swap;
		end_sim;
	end
endmodule

bind pdc_channel pdc_chk #(.SAMPLE_CYC(SAMPLE_CYC), .RF_CYC(RF_CYC), .MEM_CYC(MEM_CYC)) u_pdc_chk (
	.core_clk_i(core_clk_i), .resetn_i(resetn_i), .instr_end_i(instr_end_i),
	.top_priority_interrupt_i(top_priority_interrupt_i), .bus_o(bus_o),
	.dma_grant_o(dma_grant_o), .dma_busy_o(dma_busy_o), .periph_we_o(periph_we_o));
`default_nettype wire
